/* File: tops_pkg.sv */
/*
 package for the capture/compare timer: register offsets, field positions,
 reset values and the operating mode enumeration.
 assumes an APB master with 32-bit data and word-aligned addresses.
*/
package tops_pkg;
    localparam int CNT_W = 16;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_OUTC = 8'h04;
    localparam logic [7:0] OFS_CAPC = 8'h08;
    localparam logic [7:0] OFS_PRSC = 8'h0C;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_CCA = 8'h14;
    localparam logic [7:0] OFS_CCB = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    // mode control fields
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_INV_CAP_BIT = 1;
    localparam int MODE_LO_BIT = 2;
    localparam int MODE_HI_BIT = 3;
    // output control fields
    localparam int OUTC_OE_BIT = 0;
    localparam int OUTC_INV_A_BIT = 1;
    localparam int OUTC_INV_B_BIT = 4;
    localparam int OUTC_OSE_BIT = 5;
    localparam int OUTC_OST_BIT = 6;
    // capture control fields
    localparam int CAPC_A_IS_CAP_BIT = 0;
    localparam int CAPC_A_SRC_BIT = 1;
    localparam int CAPC_B_IS_CAP_BIT = 2;
    // trigger edge select and divider fields in prescaler register
    localparam int PRSC_EDGE_A_LSB = 4;
    localparam int PRSC_EDGE_B_LSB = 6;
    localparam int PRSC_DIV_LSB = 0;
    localparam int PRSC_DIV_W = 2;
    // edge select codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    typedef enum logic [1:0] {
        TOPS_STOP,
        TOPS_FREE,
        TOPS_EDGE_CLR,
        TOPS_MATCH_CLR
    } tops_mode_t;
endpackage

/* File: tops_prescaler.sv */
/*
 prescaler: one-cycle count enable pulse every 2**div pclk cycles
 (div code 0..3 selects a pulse every 1, 2, 4 or 8 cycles).
 assumes a single pclk domain and asynchronous active-low reset.
*/
module tops_prescaler #(
    parameter int DIV_W = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [DIV_W-1:0] div_sel,
    // enable out
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
    } tops_psc_st_t;
    tops_psc_st_t st;
    tops_psc_st_t next_st;
    logic [7:0] limit;

    always_comb
    begin
        next_st = st;
        limit = 8'((8'h01 << div_sel) - 8'h01);
        tick = 1'b0;
        if (!run)
        begin
            next_st.cnt = 8'h00;
        end
        else if (st.cnt >= limit)
        begin
            next_st.cnt = 8'h00;
            tick = 1'b1;
        end
        else
        begin
            next_st.cnt = 8'(st.cnt + 8'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
endmodule

/* File: tops_timer.sv */
/*
 16-bit up-counter with two capture/compare registers: free-running,
 pin-edge clear-and-start, match-clear (pulse generator) and one-shot pulse.
 assumes an APB master; trigger pins already synchronous to pclk.
*/
// Local design decisions: the register offsets and the APB slave port.
// Behaviour
// - pulse mode: match on register a raises irq a and clears counter.
// - pulse mode: match on register b raises irq b, counter unchanged.
// - period is a plus one clocks; high time is b plus one; here from reset the low time is b plus one, the high time a minus b.
// - one-shot works in modes 01 or 10 with enable bit 5 set.
// - soft trigger bit 6 or pin a edge restarts counter, one pulse.
// - one-shot: each compare match raises its irq and flips output.
// - pulse starts a plus one clocks after trigger, lasts b minus a.
// - overflow flag in mode bit 0; software checks and clears it.
// - free mode: pin a edge captures into b, pin b into a.
// - single-input: opposite edge captures into a, valid edge into b.
// - mode 10: pin a valid edge captures into b and zeroes counter.
// - free mode counts up, sets overflow after all ones, wraps.
module tops_timer (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trigger pins
    input wire logic trigger_pin_a,
    input wire logic trigger_pin_b,
    // timer output and events
    output logic timer_out_pin,
    output logic timer_out_oe,
    output logic match_irq_a,
    output logic match_irq_b
);
    localparam int W = tops_pkg::CNT_W;
    typedef struct packed {
        logic [3:0] mode_control_reg;
        logic [6:0] output_control_reg;
        logic [2:0] capture_control_reg;
        logic [7:0] prescaler_reg;
        logic [W-1:0] up_counter;
        logic [W-1:0] cmp_cap_reg_a;
        logic [W-1:0] cmp_cap_reg_b;
        logic tout;
        logic irq_a;
        logic irq_b;
        logic pin_a_q;
        logic pin_b_q;
        logic [31:0] rdata;
    } tops_st_t;
    tops_st_t st;
    tops_st_t next_st;
    logic tick;
    logic wr;
    logic rd;
    logic [1:0] mode;
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic valid_a;
    logic opp_a;
    logic valid_b;
    logic oneshot;
    logic soft_trig;
    logic trig;
    logic match_a;
    logic match_b;
    logic [1:0] esel_a;
    logic [1:0] esel_b;

    tops_prescaler #(
        .DIV_W(tops_pkg::PRSC_DIV_W)
    ) u_psc (
        .pclk(pclk),
        .presetn(presetn),
        .run(mode != 2'(tops_pkg::TOPS_STOP)),
        .div_sel(st.prescaler_reg[tops_pkg::PRSC_DIV_LSB +:
            tops_pkg::PRSC_DIV_W]),
        .tick(tick)
    );

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign mode = st.mode_control_reg[tops_pkg::MODE_HI_BIT:
        tops_pkg::MODE_LO_BIT];
    assign esel_a = st.prescaler_reg[tops_pkg::PRSC_EDGE_A_LSB +: 2];
    assign esel_b = st.prescaler_reg[tops_pkg::PRSC_EDGE_B_LSB +: 2];
    assign rise_a = trigger_pin_a && !st.pin_a_q;
    assign fall_a = !trigger_pin_a && st.pin_a_q;
    assign rise_b = trigger_pin_b && !st.pin_b_q;
    assign fall_b = !trigger_pin_b && st.pin_b_q;
    assign valid_a = (esel_a == tops_pkg::EDGE_BOTH) ? (rise_a || fall_a) :
        (esel_a == tops_pkg::EDGE_RISE) ? rise_a : fall_a;
    assign opp_a = (esel_a == tops_pkg::EDGE_RISE) ? fall_a :
        (esel_a == tops_pkg::EDGE_FALL) ? rise_a : 1'b0;
    assign valid_b = (esel_b == tops_pkg::EDGE_BOTH) ? (rise_b || fall_b) :
        (esel_b == tops_pkg::EDGE_RISE) ? rise_b : fall_b;
    assign oneshot = st.output_control_reg[tops_pkg::OUTC_OSE_BIT] &&
        (mode == 2'(tops_pkg::TOPS_FREE) ||
        mode == 2'(tops_pkg::TOPS_EDGE_CLR));
    assign soft_trig = wr && paddr == tops_pkg::OFS_OUTC &&
        pwdata[tops_pkg::OUTC_OST_BIT];
    assign trig = oneshot && (soft_trig || valid_a);
    assign match_a = tick && mode != 2'(tops_pkg::TOPS_STOP) &&
        !st.capture_control_reg[tops_pkg::CAPC_A_IS_CAP_BIT] &&
        st.up_counter == st.cmp_cap_reg_a;
    assign match_b = tick && mode != 2'(tops_pkg::TOPS_STOP) &&
        !st.capture_control_reg[tops_pkg::CAPC_B_IS_CAP_BIT] &&
        st.up_counter == st.cmp_cap_reg_b;

    always_comb
    begin
        next_st = st;
        next_st.pin_a_q = trigger_pin_a;
        next_st.pin_b_q = trigger_pin_b;
        next_st.irq_a = 1'b0;
        next_st.irq_b = 1'b0;
        // counter: cleared to zero in mode 00 and on match a in mode 11, one step per tick otherwise
        if (mode == 2'(tops_pkg::TOPS_STOP))
        begin
            next_st.up_counter = tops_pkg::CNT_ZERO;
        end
        else if (tick)
        begin
            if (mode == 2'(tops_pkg::TOPS_MATCH_CLR) && match_a)
                next_st.up_counter = tops_pkg::CNT_ZERO;
            else
                next_st.up_counter = W'(st.up_counter +
                    tops_pkg::CNT_ONE);
            if (st.up_counter == tops_pkg::CNT_MAX &&
                !(mode == 2'(tops_pkg::TOPS_MATCH_CLR) && match_a))
                next_st.mode_control_reg[tops_pkg::MODE_OVF_BIT] =
                    1'b1;
        end
        // compare matches
        if (match_a)
        begin
            next_st.irq_a = 1'b1;
            if (st.output_control_reg[tops_pkg::OUTC_INV_A_BIT] || oneshot)
                next_st.tout = !st.tout;
        end
        if (match_b)
        begin
            next_st.irq_b = 1'b1;
            if (st.output_control_reg[tops_pkg::OUTC_INV_B_BIT] || oneshot)
                next_st.tout = !next_st.tout;
        end
        // captures
        if (mode != 2'(tops_pkg::TOPS_STOP))
        begin
            if (st.capture_control_reg[tops_pkg::CAPC_B_IS_CAP_BIT] &&
                valid_a)
            begin
                next_st.cmp_cap_reg_b = st.up_counter;
                next_st.irq_b = 1'b1;
            end
            if (st.capture_control_reg[tops_pkg::CAPC_A_IS_CAP_BIT])
            begin
                if (st.capture_control_reg[tops_pkg::CAPC_A_SRC_BIT] &&
                    opp_a)
                    next_st.cmp_cap_reg_a = st.up_counter;
                else if (!st.capture_control_reg[tops_pkg::CAPC_A_SRC_BIT]
                    && valid_b)
                begin
                    next_st.cmp_cap_reg_a = st.up_counter;
                    next_st.irq_a = 1'b1;
                end
            end
            if (mode == 2'(tops_pkg::TOPS_EDGE_CLR) && valid_a)
                next_st.up_counter = tops_pkg::CNT_ZERO;
        end
        if (trig)
        begin
            next_st.up_counter = tops_pkg::CNT_ZERO;
        end
        // register writes; hardware overflow set wins over clear
        if (wr)
        begin
            case (paddr)
                tops_pkg::OFS_MODE:
                begin
                    next_st.mode_control_reg = pwdata[3:0];
                    if (next_st.mode_control_reg[tops_pkg::MODE_OVF_BIT] ==
                        1'b0 && tick && st.up_counter == tops_pkg::CNT_MAX &&
                        mode != 2'(tops_pkg::TOPS_STOP) &&
                        !(mode == 2'(tops_pkg::TOPS_MATCH_CLR) && match_a))
                        next_st.mode_control_reg[tops_pkg::MODE_OVF_BIT] =
                            1'b1;
                end
                tops_pkg::OFS_OUTC:
                begin
                    next_st.output_control_reg = pwdata[6:0];
                    next_st.output_control_reg[tops_pkg::OUTC_OST_BIT] = 1'b0;
                end
                tops_pkg::OFS_CAPC: next_st.capture_control_reg = pwdata[2:0];
                tops_pkg::OFS_PRSC: next_st.prescaler_reg = pwdata[7:0];
                tops_pkg::OFS_CCA: next_st.cmp_cap_reg_a = pwdata[W-1:0];
                tops_pkg::OFS_CCB: next_st.cmp_cap_reg_b = pwdata[W-1:0];
                default: next_st.rdata = st.rdata;
            endcase
        end
        if (rd)
        begin
            case (paddr)
                tops_pkg::OFS_MODE: next_st.rdata =
                    {28'h0, st.mode_control_reg};
                tops_pkg::OFS_OUTC: next_st.rdata =
                    {25'h0, st.output_control_reg};
                tops_pkg::OFS_CAPC: next_st.rdata =
                    {29'h0, st.capture_control_reg};
                tops_pkg::OFS_PRSC: next_st.rdata = {24'h0, st.prescaler_reg};
                tops_pkg::OFS_CNT: next_st.rdata = {16'h0, st.up_counter};
                tops_pkg::OFS_CCA: next_st.rdata = {16'h0, st.cmp_cap_reg_a};
                tops_pkg::OFS_CCB: next_st.rdata = {16'h0, st.cmp_cap_reg_b};
                tops_pkg::OFS_STAT: next_st.rdata = {31'h0, st.tout};
                default: next_st.rdata = tops_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign timer_out_pin = st.tout;
    assign timer_out_oe = st.output_control_reg[tops_pkg::OUTC_OE_BIT];
    assign match_irq_a = st.irq_a;
    assign match_irq_b = st.irq_b;

    // checks
    property p_clr_a;
        @(posedge pclk) disable iff (!presetn)
        (mode == 2'(tops_pkg::TOPS_MATCH_CLR) && match_a && !wr)
            |=> st.up_counter == tops_pkg::CNT_ZERO && match_irq_a;
    endproperty
    a_clr_a: assert property (p_clr_a)
        else $error("no clear on match a");
    property p_keep_b;
        @(posedge pclk) disable iff (!presetn)
        (mode == 2'(tops_pkg::TOPS_MATCH_CLR) && match_b && !match_a && !wr)
            |=> st.up_counter == W'($past(st.up_counter) + 1) && match_irq_b;
    endproperty
    a_keep_b: assert property (p_keep_b)
        else $error("match b disturbed");
    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        mode == 2'(tops_pkg::TOPS_STOP)
            |=> st.up_counter == tops_pkg::CNT_ZERO;
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter ran stopped");
    property p_ovf;
        @(posedge pclk) disable iff (!presetn)
        (mode == 2'(tops_pkg::TOPS_FREE) && tick &&
            st.up_counter == tops_pkg::CNT_MAX && !trig && !valid_a)
            |=> st.mode_control_reg[tops_pkg::MODE_OVF_BIT] &&
            st.up_counter == tops_pkg::CNT_ZERO;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow missed");
    property p_trig;
        @(posedge pclk) disable iff (!presetn)
        trig |=> st.up_counter == tops_pkg::CNT_ZERO;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger no restart");
    property p_inv;
        @(posedge pclk) disable iff (!presetn)
        (oneshot && match_a && !match_b) |=> timer_out_pin != $past(st.tout);
    endproperty
    a_inv: assert property (p_inv)
        else $error("no toggle");
    property p_cap_b;
        @(posedge pclk) disable iff (!presetn)
        (mode != 2'(tops_pkg::TOPS_STOP) && valid_a && !wr &&
            st.capture_control_reg[tops_pkg::CAPC_B_IS_CAP_BIT])
            |=> st.cmp_cap_reg_b == $past(st.up_counter);
    endproperty
    a_cap_b: assert property (p_cap_b)
        else $error("capture b lost");
    property p_edge_clr;
        @(posedge pclk) disable iff (!presetn)
        (mode == 2'(tops_pkg::TOPS_EDGE_CLR) && valid_a && !wr)
            |=> st.up_counter == tops_pkg::CNT_ZERO;
    endproperty
    a_edge_clr: assert property (p_edge_clr)
        else $error("no edge clear");
    c_ppg: cover property (@(posedge pclk) disable iff (!presetn)
        mode == 2'(tops_pkg::TOPS_MATCH_CLR) && match_a);
    c_os: cover property (@(posedge pclk) disable iff (!presetn) trig);
    c_cap: cover property (@(posedge pclk) disable iff (!presetn)
        valid_b && st.capture_control_reg[tops_pkg::CAPC_A_IS_CAP_BIT]);
endmodule

/* File: tops_pin_model.sv */
/*
 far-side model of the trigger inputs: drives pin a and pin b with the
 levels the bench asks for, one pclk after the request.
 assumes the bench changes the requests right after a rising pclk edge.
*/
module tops_pin_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels asked for by the bench
    input wire logic lvl_a,
    input wire logic lvl_b,
    // trigger pins towards the timer
    output logic trigger_pin_a,
    output logic trigger_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins move only on request: a new trigger waits for the pulse end,
    // pin a stays put while software triggers, both pins may toggle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_pin_a <= 1'b0;
            trigger_pin_b <= 1'b0;
        end
        else
        begin
            trigger_pin_a <= lvl_a;
            trigger_pin_b <= lvl_b;
        end
    end
endmodule

/* File: tb_timer_oneshot_pulse_measure.sv */
/*
 self-checking bench for the capture/compare timer: apb tasks and one
 task for each scenario.
 assumes tops_pkg, tops_timer and tops_pin_model are compiled first.
*/
module tb_timer_oneshot_pulse_measure;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;
    logic pin_a;
    logic pin_b;
    logic tout;
    logic toe;
    logic irq_a;
    logic irq_b;
    logic [31:0] ra;
    logic [31:0] rb;
    logic [31:0] rx;
    int fail_count = 0;
    int samples_checked = 0;
    int n;
    int h;

    always #10 pclk = ~pclk;

    tops_pin_model pm (.pclk(pclk), .presetn(presetn), .lvl_a(lvl_a),
        .lvl_b(lvl_b), .trigger_pin_a(pin_a), .trigger_pin_b(pin_b));

    tops_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_pin_a(pin_a), .trigger_pin_b(pin_b),
        .timer_out_pin(tout), .timer_out_oe(toe), .match_irq_a(irq_a),
        .match_irq_b(irq_b));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 50)
            chk(32'h0, 32'h1);
        rd = prdata;
        chk(pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rx);
    endtask

    function automatic logic probe(input int k);
        case (k)
            0: return irq_a;
            1: return irq_b;
            default: return tout;
        endcase
    endfunction

    // edges until the probed output is sampled at level v
    task wait_lvl(input int k, input logic v);
        n = 0;
        while (probe(k) !== v && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000)
            chk(32'h0, 32'h1);
    endtask

    task gap(input int k1, input int k2);
        wait_lvl(k1, 1'b1);
        @(posedge pclk);
        wait_lvl(k2, 1'b1);
        n++;
    endtask

    task t_reset;
        apb(1'b0, tops_pkg::OFS_MODE, 32'h0, ra);
        chk(ra, 32'h0);
        apb(1'b0, tops_pkg::OFS_CNT, 32'h0, ra);
        apb(1'b0, tops_pkg::OFS_CNT, 32'h0, rb);
        chk(rb, 32'h0);
        apb(1'b0, 8'h40, 32'h0, ra);
        chk(ra, 32'h0);
    endtask

    task t_free;
        wr(tops_pkg::OFS_MODE, 32'h4);
        apb(1'b0, tops_pkg::OFS_CNT, 32'h0, ra);
        apb(1'b0, tops_pkg::OFS_CNT, 32'h0, rb);
        chk(rb - ra, 32'h3);
    endtask

    task t_ppg;
        wr(tops_pkg::OFS_MODE, 32'h0);
        wr(tops_pkg::OFS_CCA, 32'h9);
        wr(tops_pkg::OFS_CCB, 32'h3);
        wr(tops_pkg::OFS_OUTC, 32'h13);
        wr(tops_pkg::OFS_MODE, 32'hC);
        chk(toe, 1'b1);
        gap(0, 0);
        chk(n, 32'hA);
        gap(0, 1);
        chk(n, 32'h4);
        h = 0;
        repeat (10)
        begin
            @(posedge pclk);
            if (tout === 1'b1)
                h++;
        end
        chk(h == 4 || h == 6, 32'h1);
    endtask

    task t_oneshot(input logic [31:0] mode, input logic by_pin);
        logic idle;
        wr(tops_pkg::OFS_MODE, 32'h0);
        wr(tops_pkg::OFS_CCA, 32'h5);
        wr(tops_pkg::OFS_CCB, 32'hC);
        wr(tops_pkg::OFS_PRSC, 32'h10);
        wr(tops_pkg::OFS_OUTC, 32'h33);
        wr(tops_pkg::OFS_MODE, mode);
        // the output only toggles, so the pulse is the inverse of this level
        idle = tout;
        if (by_pin)
            lvl_a <= 1'b1;
        else
            wr(tops_pkg::OFS_OUTC, 32'h73);
        wait_lvl(2, !idle);
        chk(n >= 6 && n <= 9, 32'h1);
        wait_lvl(2, idle);
        chk(n, 32'h7);
        apb(1'b0, tops_pkg::OFS_OUTC, 32'h0, ra);
        chk(ra, 32'h33);
        h = 0;
        repeat (40)
        begin
            @(posedge pclk);
            if (tout !== idle)
                h++;
        end
        chk(h, 32'h0);
    endtask

    task t_capture;
        wr(tops_pkg::OFS_MODE, 32'h0);
        wr(tops_pkg::OFS_OUTC, 32'h0);
        wr(tops_pkg::OFS_CAPC, 32'h5);
        wr(tops_pkg::OFS_PRSC, 32'hF0);
        wr(tops_pkg::OFS_MODE, 32'h4);
        lvl_a <= ~lvl_a;
        repeat (20) @(posedge pclk);
        lvl_b <= ~lvl_b;
        repeat (5) @(posedge pclk);
        apb(1'b0, tops_pkg::OFS_CCA, 32'h0, ra);
        apb(1'b0, tops_pkg::OFS_CCB, 32'h0, rb);
        chk(ra - rb, 32'h14);
    endtask

    task t_single(input logic [31:0] mode);
        wr(tops_pkg::OFS_MODE, 32'h0);
        wr(tops_pkg::OFS_OUTC, 32'h0);
        wr(tops_pkg::OFS_CAPC, 32'h7);
        wr(tops_pkg::OFS_PRSC, 32'h10);
        lvl_a <= 1'b0;
        wr(tops_pkg::OFS_MODE, mode);
        lvl_a <= 1'b1;
        repeat (10) @(posedge pclk);
        lvl_a <= 1'b0;
        repeat (15) @(posedge pclk);
        lvl_a <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, tops_pkg::OFS_CCA, 32'h0, ra);
        apb(1'b0, tops_pkg::OFS_CCB, 32'h0, rb);
        chk(rb - ra, 32'hF);
        apb(1'b0, tops_pkg::OFS_CNT, 32'h0, ra);
        chk(ra < 32'h14, mode == 32'h8);
    endtask

    task t_overflow;
        wr(tops_pkg::OFS_MODE, 32'h0);
        wr(tops_pkg::OFS_MODE, 32'h4);
        repeat (65540) @(posedge pclk);
        apb(1'b0, tops_pkg::OFS_MODE, 32'h0, ra);
        chk(ra[3:0], 4'h5);
        wr(tops_pkg::OFS_MODE, 32'h4);
        apb(1'b0, tops_pkg::OFS_MODE, 32'h0, ra);
        chk(ra[3:0], 4'h4);
    endtask

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_free;
        t_ppg;
        t_oneshot(32'h4, 1'b0);
        t_oneshot(32'h8, 1'b0);
        t_oneshot(32'h4, 1'b1);
        t_capture;
        t_single(32'h4);
        t_single(32'h8);
        t_overflow;
        end_of_test;
    end

    // cuts a hang short well after the overflow wait
    initial
    begin
        repeat (90000) @(posedge pclk);
        fail_count++;
        end_of_test;
    end
endmodule
